// ---- design/pcr_pkg.sv ----
// Package of constants and types for the calibration packet responder.
// Overview of operation
// R01: Failed identity verification answers NAK.
// R02: Identity packets unsupported answer not-defined response.
// R03: Verify identity packet by CRC before replying.
// R04: Proprietary packet: own reply else not-defined.
// R05: Reserved header in negotiation answers not-defined.
// R06: Calibration keeps power transfer behaviour plus reports.
// R07: Light-load report: ACK if acceptable, else NAK.
// R08: Connected-load acceptable: ACK, enter power transfer.
// R09: Other calibration report mode: drop power, select.
// R10: No acceptable report in time: drop power.
// R11: Missing light or connected info: drop power.
// R12: Use calibration data only when no object.
// R13: Receiver reports light load then connected load.
// R14: NAK light load above fifteen percent maximum.
// R15: NAK connected load before light load ACK.
// R16: Power transfer: modes 001/010 answer not-defined.
// R17: After power removal return to selection phase.
// R18: Light-load ACK flag cleared on calibration entry.
package pcr_pkg;
  typedef enum logic [2:0] {
    PCR_PH_SELECT    = 3'b000,
    PCR_PH_NEGOTIATE = 3'b001,
    PCR_PH_CALIB     = 3'b010,
    PCR_PH_TRANSFER  = 3'b011
  } pcr_phase_type;

  typedef enum logic [2:0] {
    PCR_PK_IDENT    = 3'b000,
    PCR_PK_PROPR    = 3'b001,
    PCR_PK_RESERVED = 3'b010,
    PCR_PK_RXPOWER  = 3'b011,
    PCR_PK_OTHER    = 3'b100
  } pcr_pkt_type;

  typedef enum logic [1:0] {
    PCR_RSP_ACK         = 2'b00,
    PCR_RSP_NAK         = 2'b01,
    PCR_RSP_NOT_DEFINED = 2'b10,
    PCR_RSP_DATA        = 2'b11
  } pcr_rsp_type;

  localparam logic [2:0] PCR_MODE_LIGHT     = 3'h1;
  localparam logic [2:0] PCR_MODE_CONNECTED = 3'h2;
  localparam int unsigned PCR_PWR_W         = 16;
  localparam int unsigned PCR_PCT_LIMIT     = 15;
  localparam int unsigned PCR_PCT_FULL      = 100;
  localparam int unsigned PCR_CLK_HZ        = 25000000;
  localparam int unsigned PCR_CAL_LIMIT_S   = 10;
  localparam int unsigned PCR_CAL_CYCLES    = PCR_CAL_LIMIT_S * PCR_CLK_HZ;
endpackage

// ---- design/pcr_responder.sv ----
// Calibration and negotiation packet responder of a power_transmitter.
`timescale 1ns/1ps
`default_nettype none
module pcr_responder
  import pcr_pkg::*;
#(
  parameter int unsigned CAL_CYCLES     = PCR_CAL_CYCLES,
  parameter bit          IDENT_SUPPORT  = 1'b1
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic                 pkt_valid,
  input  wire pcr_pkt_type          pkt_kind,
  input  wire logic [2:0]           pkt_mode,
  input  wire logic [PCR_PWR_W-1:0] pkt_power,
  input  wire logic                 pkt_is_24bit,
  input  wire logic                 ident_crc_ok,
  input  wire logic                 prop_has_reply,
  input  wire pcr_rsp_type          prop_reply,
  input  wire logic [PCR_PWR_W-1:0] rx_max_power,
  input  wire logic                 loss_ok,
  input  wire logic                 no_foreign_object,
  input  wire logic                 enter_negotiate,
  input  wire logic                 enter_calib,
  output logic                      rsp_valid,
  output pcr_rsp_type               rsp_code,
  output pcr_phase_type             phase,
  output logic                      power_off,
  output logic                      light_acked,
  output logic                      cal_data_use
);
  pcr_phase_type     phase_q, phase_d;
  pcr_rsp_type       rsp_q, rsp_d;
  logic              rv_q, rv_d, off_q, off_d, lack_q, lack_d, use_q, use_d;
  logic [31:0]       tmr_q, tmr_d;
  logic [PCR_PWR_W+7:0] lhs, rhs;
  logic              light_ok;

  // One clock domain, so every check shares this clock and reset.
  default clocking pcr_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // Power above fifteen percent of maximum is refused as a light load.
  always_comb begin
    lhs = {8'h00, pkt_power} * (PCR_PWR_W+8)'(PCR_PCT_FULL);
    rhs = {8'h00, rx_max_power} * (PCR_PWR_W+8)'(PCR_PCT_LIMIT);
    light_ok = (lhs <= rhs) && loss_ok; // R14
  end

  always_comb begin
    phase_d = phase_q;
    rsp_d   = rsp_q;
    rv_d    = 1'b0;
    off_d   = 1'b0;
    lack_d  = lack_q;
    use_d   = use_q;
    tmr_d   = tmr_q;
    case (phase_q)
      PCR_PH_SELECT: begin
        if (enter_negotiate) begin
          phase_d = PCR_PH_NEGOTIATE;
        end
      end
      PCR_PH_NEGOTIATE: begin
        if (enter_calib) begin
          phase_d = PCR_PH_CALIB;
          lack_d  = 1'b0; // R18
          use_d   = 1'b0;
          tmr_d   = '0;
        end else if (pkt_valid) begin
          rv_d = 1'b1;
          case (pkt_kind)
            PCR_PK_IDENT: begin
              if (!IDENT_SUPPORT) begin
                rsp_d = PCR_RSP_NOT_DEFINED; // R02
              end else if (ident_crc_ok) begin // R03
                rsp_d = PCR_RSP_ACK;
              end else begin
                rsp_d = PCR_RSP_NAK; // R01
              end
            end
            PCR_PK_PROPR: begin
              rsp_d = prop_has_reply ? prop_reply : PCR_RSP_NOT_DEFINED; // R04
            end
            PCR_PK_RESERVED: begin
              rsp_d = PCR_RSP_NOT_DEFINED; // R05
            end
            default: begin
              rv_d = 1'b0;
            end
          endcase
        end
      end
      PCR_PH_CALIB: begin
        tmr_d = tmr_q + 32'h00000001;
        if (tmr_q >= CAL_CYCLES - 1) begin
          // Connected-load report not accepted in time: give up the power signal.
          off_d   = 1'b1; // R10 R11
          phase_d = PCR_PH_SELECT; // R17
        end else if (pkt_valid && pkt_kind == PCR_PK_RXPOWER
                     && pkt_is_24bit) begin // R06
          if (pkt_mode == PCR_MODE_LIGHT) begin
            rv_d = 1'b1;
            if (light_ok) begin
              rsp_d  = PCR_RSP_ACK; // R07
              lack_d = 1'b1; // R18
            end else begin
              rsp_d = PCR_RSP_NAK; // R07
            end
          end else if (pkt_mode == PCR_MODE_CONNECTED) begin
            rv_d = 1'b1;
            if (lack_q && loss_ok) begin // R15
              rsp_d   = PCR_RSP_ACK; // R08
              phase_d = PCR_PH_TRANSFER;
              use_d   = no_foreign_object; // R12
            end else begin
              rsp_d = PCR_RSP_NAK; // R08
            end
          end else begin
            off_d   = 1'b1; // R09
            phase_d = PCR_PH_SELECT; // R17
          end
        end
      end
      PCR_PH_TRANSFER: begin
        if (pkt_valid && pkt_kind == PCR_PK_RXPOWER &&
            (pkt_mode == PCR_MODE_LIGHT ||
             pkt_mode == PCR_MODE_CONNECTED)) begin
          rv_d  = 1'b1;
          rsp_d = PCR_RSP_NOT_DEFINED; // R16
        end
      end
      default: begin
        phase_d = PCR_PH_SELECT;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= PCR_PH_SELECT;
      rsp_q   <= PCR_RSP_NOT_DEFINED;
      rv_q    <= 1'b0;
      off_q   <= 1'b0;
      lack_q  <= 1'b0;
      use_q   <= 1'b0;
      tmr_q   <= '0;
    end else begin
      phase_q <= phase_d;
      rsp_q   <= rsp_d;
      rv_q    <= rv_d;
      off_q   <= off_d;
      lack_q  <= lack_d;
      use_q   <= use_d;
      tmr_q   <= tmr_d;
    end
  end

  assign rsp_valid    = rv_q;
  assign rsp_code     = rsp_q;
  assign phase        = phase_q;
  assign power_off    = off_q;
  assign light_acked  = lack_q;
  assign cal_data_use = use_q;

  chk_conn_needs_light: assert property ( // R15
    (phase_q == PCR_PH_CALIB && phase_d == PCR_PH_TRANSFER) |-> lack_q)
    else $error("Connected load accepted without light ACK.");
  chk_light_nak_resp: assert property ( // R07
    (phase_q == PCR_PH_CALIB && pkt_valid && pkt_kind == PCR_PK_RXPOWER &&
     pkt_is_24bit && pkt_mode == PCR_MODE_LIGHT && !light_ok &&
     tmr_q < CAL_CYCLES - 1) |=> (rv_q && rsp_q == PCR_RSP_NAK))
    else $error("Light load not NAKed.");
  chk_conn_ack_move: assert property ( // R08
    (phase_q == PCR_PH_CALIB && pkt_valid && pkt_kind == PCR_PK_RXPOWER &&
     pkt_is_24bit && pkt_mode == PCR_MODE_CONNECTED && lack_q && loss_ok &&
     tmr_q < CAL_CYCLES - 1) |=> (rv_q && rsp_q == PCR_RSP_ACK &&
     phase_q == PCR_PH_TRANSFER))
    else $error("Accepted connected load did not enter transfer.");
  chk_bad_mode_off: assert property ( // R09
    (phase_q == PCR_PH_CALIB && pkt_valid && pkt_kind == PCR_PK_RXPOWER &&
     pkt_is_24bit && pkt_mode != PCR_MODE_LIGHT &&
     pkt_mode != PCR_MODE_CONNECTED) |=> (off_q && !rv_q))
    else $error("Unknown calibration mode kept power on.");
  chk_transfer_undef_resp: assert property ( // R16
    (phase_q == PCR_PH_TRANSFER && pkt_valid && pkt_kind == PCR_PK_RXPOWER &&
     pkt_mode == PCR_MODE_LIGHT) |=> (rv_q && rsp_q == PCR_RSP_NOT_DEFINED))
    else $error("Transfer phase light report not answered not-defined.");
  chk_transfer_conn_undef: assert property ( // R16
    (phase_q == PCR_PH_TRANSFER && pkt_valid && pkt_kind == PCR_PK_RXPOWER &&
     pkt_mode == PCR_MODE_CONNECTED) |=> (rv_q && rsp_q == PCR_RSP_NOT_DEFINED))
    else $error("Transfer phase connected report not answered not-defined.");
  chk_off_to_select: assert property ( // R17
    $rose(off_q) |-> phase_q == PCR_PH_SELECT)
    else $error("Power removed without return to selection.");
  chk_reserved_undef: assert property ( // R05
    (phase_q == PCR_PH_NEGOTIATE && !enter_calib && pkt_valid &&
     pkt_kind == PCR_PK_RESERVED) |=> rsp_q == PCR_RSP_NOT_DEFINED)
    else $error("Reserved packet not answered not-defined.");
  chk_ident_nak: assert property ( // R01
    (phase_q == PCR_PH_NEGOTIATE && !enter_calib && pkt_valid &&
     pkt_kind == PCR_PK_IDENT && IDENT_SUPPORT && !ident_crc_ok)
    |=> rsp_q == PCR_RSP_NAK)
    else $error("Failed identity not NAKed.");
  chk_ident_unsupported: assert property ( // R02
    (phase_q == PCR_PH_NEGOTIATE && !enter_calib && pkt_valid &&
     pkt_kind == PCR_PK_IDENT && !IDENT_SUPPORT)
    |=> rsp_q == PCR_RSP_NOT_DEFINED)
    else $error("Unsupported identity not answered not-defined.");
  chk_prop_default: assert property ( // R04
    (phase_q == PCR_PH_NEGOTIATE && !enter_calib && pkt_valid &&
     pkt_kind == PCR_PK_PROPR && !prop_has_reply)
    |=> rsp_q == PCR_RSP_NOT_DEFINED)
    else $error("Proprietary default not answered not-defined.");
  chk_cal_timeout: assert property ( // R10
    (phase_q == PCR_PH_CALIB && tmr_q >= CAL_CYCLES - 1) |=>
    (off_q && phase_q == PCR_PH_SELECT))
    else $error("Calibration timeout ignored.");
  chk_entry_clear: assert property ( // R18
    (phase_q == PCR_PH_NEGOTIATE && enter_calib) |=> !lack_q)
    else $error("Light flag not cleared on entry.");
  chk_data_use_gate: assert property ( // R12
    $rose(use_q) |-> $past(no_foreign_object))
    else $error("Calibration data used with an object present.");
  cov_cal_done: cover property (
    phase_q == PCR_PH_CALIB ##1 phase_q == PCR_PH_TRANSFER);
  cov_bad_mode: cover property (
    phase_q == PCR_PH_CALIB ##1 $rose(off_q));
  cov_light_ack: cover property (
    $rose(lack_q));
  cov_light_nak: cover property (
    rv_q && rsp_q == PCR_RSP_NAK && phase_q == PCR_PH_CALIB);
endmodule
`default_nettype wire

// ---- verification/pcr_responder_bench.sv ----
// Self-checking bench of the calibration packet responder.
`timescale 1ns/1ps
`default_nettype none
module pcr_responder_bench;
  import pcr_pkg::*;
  localparam int unsigned CALN = 50;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic pkt_valid, pkt_is_24bit, ident_crc_ok, prop_has_reply, loss_ok;
  logic no_foreign_object, enter_negotiate, enter_calib, rsp_valid;
  logic power_off, light_acked, cal_data_use;
  logic [2:0] pkt_mode;
  logic [15:0] pkt_power, rx_max_power;
  pcr_pkt_type pkt_kind;
  pcr_rsp_type prop_reply, rsp_code;
  pcr_phase_type phase;
  pcr_rsp_type nid_rsp_code;
  int err_count = 0;
  int comparisons = 0;
  pcr_rsp_type exp_q[$];
  always #20 ref_clk = ~ref_clk;
  pcr_rx_model i_pcr_rx_model (.ref_clk(ref_clk), .pkt_valid(pkt_valid),
    .pkt_kind(pkt_kind), .pkt_mode(pkt_mode), .pkt_power(pkt_power),
    .pkt_is_24bit(pkt_is_24bit));
  pcr_responder #(.CAL_CYCLES(CALN)) i_pcr_responder (.ref_clk(ref_clk),
    .rst_n(rst_n), .pkt_valid(pkt_valid), .pkt_kind(pkt_kind),
    .pkt_mode(pkt_mode), .pkt_power(pkt_power), .pkt_is_24bit(pkt_is_24bit),
    .ident_crc_ok(ident_crc_ok), .prop_has_reply(prop_has_reply),
    .prop_reply(prop_reply), .rx_max_power(rx_max_power), .loss_ok(loss_ok),
    .no_foreign_object(no_foreign_object), .enter_negotiate(enter_negotiate),
    .enter_calib(enter_calib), .rsp_valid(rsp_valid), .rsp_code(rsp_code),
    .phase(phase), .power_off(power_off), .light_acked(light_acked),
    .cal_data_use(cal_data_use));
  // A copy without identity support answers the same packets beside it.
  pcr_responder #(.CAL_CYCLES(CALN), .IDENT_SUPPORT(1'b0))
    i_pcr_responder_nid (.ref_clk(ref_clk), .rst_n(rst_n),
    .pkt_valid(pkt_valid), .pkt_kind(pkt_kind), .pkt_mode(pkt_mode),
    .pkt_power(pkt_power), .pkt_is_24bit(pkt_is_24bit),
    .ident_crc_ok(ident_crc_ok), .prop_has_reply(prop_has_reply),
    .prop_reply(prop_reply), .rx_max_power(rx_max_power), .loss_ok(loss_ok),
    .no_foreign_object(no_foreign_object), .enter_negotiate(enter_negotiate),
    .enter_calib(enter_calib), .rsp_valid(), .rsp_code(nid_rsp_code),
    .phase(), .power_off(), .light_acked(), .cal_data_use());
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Responses are matched in order; a response with no note is an error.
  always @(negedge ref_clk) if (rsp_valid === 1'b1) begin
    if (exp_q.size() == 0) check("spare response", 16'h1, 16'h0);
    else check("rsp_code", 16'(rsp_code), 16'(exp_q.pop_front()));
  end
  task automatic pk(input pcr_pkt_type k, input logic [2:0] m,
                    input logic [15:0] p, input pcr_rsp_type e);
    exp_q.push_back(e);
    i_pcr_rx_model.send(k, m, p);
    @(negedge ref_clk);
  endtask
  task automatic ent(input bit cal);
    @(negedge ref_clk);
    if (cal) enter_calib = 1'b1;
    else enter_negotiate = 1'b1;
    @(negedge ref_clk);
    enter_calib = 1'b0;
    enter_negotiate = 1'b0;
  endtask
  task automatic ph(input pcr_phase_type e);
    check("phase", 16'(phase), 16'(e));
  endtask
  initial begin
    repeat (3000) @(posedge ref_clk);
    err_count++;
    conclude();
  end
  initial begin
    {ident_crc_ok, prop_has_reply, loss_ok, no_foreign_object} = 4'hF;
    {enter_negotiate, enter_calib} = 2'h0;
    prop_reply = PCR_RSP_ACK;
    rx_max_power = 16'h03E8;
    void'($urandom(32'h9D51));
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    check("reset code", 16'(rsp_code), 16'(PCR_RSP_NOT_DEFINED));
    ent(0);
    ph(PCR_PH_NEGOTIATE);
    pk(PCR_PK_IDENT, 3'h0, 16'h0, PCR_RSP_ACK);
    ident_crc_ok = 1'b0;
    pk(PCR_PK_IDENT, 3'h0, 16'h0, PCR_RSP_NAK);
    pk(PCR_PK_RESERVED, 3'h0, 16'h0, PCR_RSP_NOT_DEFINED);
    prop_has_reply = 1'b0;
    pk(PCR_PK_PROPR, 3'h0, 16'h0, PCR_RSP_NOT_DEFINED);
    prop_has_reply = 1'b1;
    for (int i = 0; i < 4; i++) begin
      prop_reply = pcr_rsp_type'(i);
      pk(PCR_PK_PROPR, 3'h0, 16'h0, pcr_rsp_type'(i));
    end
    pk(PCR_PK_IDENT, 3'h0, 16'h0, PCR_RSP_NAK);
    check("nid rsp_code", 16'(nid_rsp_code), 16'(PCR_RSP_NOT_DEFINED));
    $display("test negotiate done");
    ent(1);
    ph(PCR_PH_CALIB);
    check("light_acked", 16'(light_acked), 16'h0);
    pk(PCR_PK_RXPOWER, PCR_MODE_CONNECTED, 16'h0010, PCR_RSP_NAK);
    pk(PCR_PK_RXPOWER, PCR_MODE_LIGHT, 16'h0097, PCR_RSP_NAK);
    pk(PCR_PK_RXPOWER, PCR_MODE_LIGHT, 16'($urandom_range(150)),
       PCR_RSP_ACK);
    check("light_acked", 16'(light_acked), 16'h1);
    pk(PCR_PK_RXPOWER, PCR_MODE_CONNECTED, 16'($urandom_range(900)),
       PCR_RSP_ACK);
    ph(PCR_PH_TRANSFER);
    check("cal_data_use", 16'(cal_data_use), 16'h1);
    pk(PCR_PK_RXPOWER, PCR_MODE_LIGHT, 16'h0020, PCR_RSP_NOT_DEFINED);
    $display("test calibrate done");
    rst_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    for (int m = 0; m < 8; m++) if (m != 1 && m != 2) begin
      ent(0);
      ent(1);
      i_pcr_rx_model.send(PCR_PK_RXPOWER, 3'(m), 16'h0010);
      check("power_off", 16'(power_off), 16'h1);
      ph(PCR_PH_SELECT);
    end
    $display("test bad mode done");
    ent(0);
    ent(1);
    pk(PCR_PK_RXPOWER, PCR_MODE_LIGHT, 16'h0096, PCR_RSP_ACK);
    ph(PCR_PH_CALIB);
    // The entry edge lies three falling edges back, so this lands half a
    // cycle after the limit, while the power-off pulse still stands.
    repeat (CALN - 3) @(negedge ref_clk);
    check("power_off", 16'(power_off), 16'h1);
    ph(PCR_PH_SELECT);
    ent(0);
    ent(1);
    check("light_acked", 16'(light_acked), 16'h0);
    $display("test timeout done");
    check("pending", 16'(exp_q.size()), 16'h0);
    conclude();
  end
endmodule
`default_nettype wire

// ---- verification/pcr_rx_model.sv ----
// Behavioural receiver controller that sends packets to the responder.
`timescale 1ns/1ps
`default_nettype none
module pcr_rx_model
  import pcr_pkg::*;
(
  input  wire logic            ref_clk,
  output logic                 pkt_valid,
  output pcr_pkt_type          pkt_kind,
  output logic [2:0]           pkt_mode,
  output logic [PCR_PWR_W-1:0] pkt_power,
  output logic                 pkt_is_24bit
);
  initial begin
    pkt_valid = 1'b0;
    pkt_kind = PCR_PK_OTHER;
    pkt_mode = 3'h0;
    pkt_power = 16'h0;
    pkt_is_24bit = 1'b0;
  end
  // Mode and power are inverted and the 24-bit flag cleared after the pulse so that stale values never match.
  task automatic send(input pcr_pkt_type k, input logic [2:0] m,
                      input logic [PCR_PWR_W-1:0] p);
    @(negedge ref_clk);
    pkt_valid = 1'b1;
    pkt_kind = k;
    pkt_mode = m;
    pkt_power = p;
    pkt_is_24bit = 1'b1;
    @(negedge ref_clk);
    pkt_valid = 1'b0;
    pkt_mode = ~m;
    pkt_power = ~p;
    pkt_is_24bit = 1'b0;
  endtask
endmodule
`default_nettype wire
